/* File: csc_pkg.sv */
// Shared constants and types of the clock synthesizer control block.
package csc_pkg;

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  localparam logic [6:0] CSC_SLAVE_ADDR = 7'h69;
  localparam int CSC_NUM_REGS = 6;
  localparam logic [2:0] CSC_FIRST_DATA_IDX = 3'h2;
  localparam logic [2:0] CSC_STRAP_REG = 3'h4;
  localparam logic [2:0] CSC_STRAP2_REG = 3'h5;
  localparam logic [7:0] CSC_REG0_RESET = 8'h00;
  localparam logic [7:0] CSC_ENABLE_RESET = 8'hFF;

  // ****************************************************************
  // Register 0 fields
  // ****************************************************************
  localparam int CSC_R0_TRISTATE = 0;
  localparam int CSC_R0_SPREAD_EN = 1;
  localparam int CSC_R0_SOFT_BIT3 = 2;
  localparam int CSC_R0_SOFT_SEL = 3;
  localparam int CSC_R0_SOFT_BIT0 = 4;
  localparam int CSC_R0_SOFT_BIT1 = 5;
  localparam int CSC_R0_SOFT_BIT2 = 6;
  localparam int CSC_R0_SPREAD_WIDE = 7;

  // ****************************************************************
  // Enable bit positions in registers 1 and 5; strap bit positions in registers 4 and 5
  // ****************************************************************
  localparam int CSC_R1_HOST1 = 1;
  localparam int CSC_R5_REFOUT0 = 0;
  localparam int CSC_R5_IRQ0 = 3;
  localparam int CSC_STRAP_POS_B0 = 7;
  localparam int CSC_STRAP_POS_B1 = 3;
  localparam int CSC_STRAP_POS_B3 = 1;
  localparam int CSC_STRAP_POS_B2 = 6;

  // ****************************************************************
  // Input synchroniser lanes
  // ****************************************************************
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_CPUH = 2;
  localparam int SY_PCIH = 3;
  localparam int SY_HOST = 4;
  localparam int SY_SDR = 5;
  localparam int SY_BUS = 6;
  localparam int SY_REF = 7;
  localparam int SY_STRAP = 8;
  localparam int SY_MODE = 12;
  localparam int CSC_SYNC_W = 13;

  // Cycles after reset release before straps are caught.
  localparam logic [1:0] CSC_STRAP_WAIT = 2'h3;

  // ****************************************************************
  // Frequency table: CPU/SDRAM clock in tenths of MHz and bus divisor
  // ****************************************************************
  localparam logic [15:0][10:0] CSC_CPU_TENTHS = {
    11'h532, 11'h4D8, 11'h5DC, 11'h578, 11'h41A, 11'h44C, 11'h47E, 11'h4B0,
    11'h3EB, 11'h532, 11'h460, 11'h406, 11'h29C, 11'h341, 11'h2EE, 11'h4D8};
  localparam logic [15:0][2:0] CSC_BUS_DIV = {
    3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h3};

  localparam int CSC_NUM_GATES = 25;

  typedef enum logic [2:0] {
    CSC_IDLE, CSC_ADDR, CSC_WR, CSC_ACK, CSC_RD, CSC_RACK
  } csc_ser_st_t;

endpackage : csc_pkg

/* File: csc_clk_gate.sv */
// Glitch-free gate for one clock output that parks low when stopped.
`timescale 1ns/1ps
module csc_clk_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic src,
  input wire logic bus_rise,
  input wire logic enable,
  output logic gated
);

  typedef struct packed {
    logic armed;
    logic prev;
    logic run;
    logic out;
  } csc_gate_t;

  csc_gate_t q;
  csc_gate_t d;

  always_comb begin
    d = q;
    d.prev = src;
    // A change waits for a free-running bus clock rise, then the next falling edge.
    if (bus_rise && (q.run != enable)) begin
      d.armed = 1'b1;
    end
    if (q.armed && q.prev && !src) begin
      d.run = enable;
      d.armed = 1'b0;
    end
    // Switching only on a falling edge keeps every high period whole.
    d.out = src & d.run;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gated = q.out;

endmodule : csc_clk_gate

/* File: csc_top.sv */
// Clock synthesizer control: straps, frequency decode, output gating, serial slave.
`timescale 1ns/1ps
// Overview of operation
// - In mobile mode reference pin 0 is an active-low bus clock halt.
// - Frequency straps 2, 1, 0 are sampled once after power-up.
// - Four-bit code selects CPU/SDRAM frequency and bus divisor of 2, 3 or 4.
// - Mode strap from free-running bus clock pin picks pin 3 function.
// - Each clock output has its own serial enable bit, except SDRAM outputs, which share one bit per group of four, and the free-running bus clock, which has none.
// - Mode 0 uses both halt pins; mode 1 ignores them.
// - Output runs only when its enable bit and its halt pin allow.
// - Stopped outputs park low without shortened high pulses.
// - Start or stop waits for bus clock rise then output falling edge.
// - CPU halt stops host, interrupt and SDRAM clocks; bus halt stops bus clocks.
// - Stored control bytes can be read back over the serial slave.
// - All control registers load defaults at power-up.
// - Write is start, address 1101 0010, command, count, then data.
// - Device pulls data low to acknowledge each received byte.
// - Read with address 1101 0011 returns bytes from 0 until stop.
// - Command and count bytes are acknowledged and ignored; data starts at register 0.
// - Register 0 bit 3 selects straps or software code in bits 6,5,4,2.
// - Register 0 bit 1 enables spread; bit 7 selects its depth.
// - Register 0 bit 0 tristates every clock output.
// - Software code uses the same frequency table as the straps.
// - Frequency strap 3 is sampled from bus clock 0 pin at power-up.
// - CPU halt input is resynchronised before gating.
module csc_top
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  input wire logic cpu_halt_n,
  input wire logic reference_out_0_i,
  input wire logic host_src_clk,
  input wire logic sdram_src_clk,
  input wire logic bus_src_clk,
  input wire logic ref_src_clk,
  input wire logic [3:0] freq_strap_pins,
  input wire logic mode_strap_pin,
  output logic [1:0] host_clk_outputs,
  output logic irq_ctrl_clk_0,
  output logic [15:0] sdram_clk_outputs,
  output logic [4:0] bus_clk_outputs,
  output logic reference_out_0,
  output logic reference_out_0_oe,
  output logic free_running_bus_clk,
  output logic clk_outputs_oe,
  output logic [3:0] freq_code,
  output logic [10:0] cpu_freq_tenths_mhz,
  output logic [2:0] bus_clk_divisor,
  output logic spread_enable,
  output logic spread_wide,
  output logic strap_mode,
  output logic straps_valid
);
  import csc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [CSC_SYNC_W-1:0] s1;
    logic [CSC_SYNC_W-1:0] s2;
    logic [CSC_SYNC_W-1:0] s3;
    csc_ser_st_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [2:0] idx;
    logic rd;
    logic sda_oe;
    logic [CSC_NUM_REGS-1:0][7:0] regs;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [3:0] fs;
    logic mode;
    logic [3:0] code;
    logic [10:0] cpu_f;
    logic [2:0] div;
    logic ss_en;
    logic ss_wide;
    logic out_oe;
    logic ref_oe;
    logic bus_clk;
  } csc_state_t;

  csc_state_t q;
  csc_state_t d;
  logic [CSC_NUM_GATES-1:0] g_src;
  logic [CSC_NUM_GATES-1:0] g_en;
  logic [CSC_NUM_GATES-1:0] g_out;
  logic bus_rise;
  logic cpu_ok;
  logic pci_ok;

  // Read-back byte at a given index; straps appear in registers 4 and 5.
  function automatic logic [7:0] read_byte(input csc_state_t s, input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i == CSC_STRAP_REG) begin
      b = 8'hFF;
      b[CSC_STRAP_POS_B0] = s.fs[0];
      b[CSC_STRAP_POS_B1] = s.fs[1];
      b[CSC_STRAP_POS_B3] = s.fs[3];
    end else if (i == CSC_STRAP2_REG) begin
      b = s.regs[CSC_STRAP2_REG];
      b[CSC_STRAP_POS_B2] = s.fs[2];
    end else if (i < 3'(CSC_NUM_REGS)) begin
      b = s.regs[i];
    end
    return b;
  endfunction : read_byte

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic scl;
    logic scl_p;
    logic sda;
    logic sda_p;
    logic [2:0] widx;
    logic [7:0] rb;
    d = q;
    scl = q.s2[SY_SCL];
    scl_p = q.s3[SY_SCL];
    sda = q.s2[SY_SDA];
    sda_p = q.s3[SY_SDA];
    widx = q.idx - CSC_FIRST_DATA_IDX;
    rb = read_byte(q, q.idx);

    d.s1 = {mode_strap_pin, freq_strap_pins, ref_src_clk, bus_src_clk, sdram_src_clk,
            host_src_clk, reference_out_0_i, cpu_halt_n, serial_data_line_i,
            serial_clock_line};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.bus_clk = q.s2[SY_BUS];

    // Straps are caught once, after the synchronisers have filled.
    if (!q.strap_done) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == CSC_STRAP_WAIT) begin
        d.fs = q.s2[SY_STRAP +: 4];
        d.mode = q.s2[SY_MODE];
        d.strap_done = 1'b1;
      end
    end

    if (scl && scl_p && !sda && sda_p) begin
      d.st = CSC_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
    end else if (scl && scl_p && sda && !sda_p) begin
      d.st = CSC_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        CSC_ADDR, CSC_WR: begin
          if (scl && !scl_p && q.bits != 4'h8) begin
            d.sh = {q.sh[6:0], sda};
            d.bits = q.bits + 4'h1;
          end
          if (!scl && scl_p && q.bits == 4'h8) begin
            d.bits = 4'h0;
            d.st = CSC_ACK;
            d.sda_oe = 1'b1;
            if (q.st == CSC_ADDR) begin
              d.rd = q.sh[0];
              d.idx = 3'h0;
              if (q.sh[7:1] != CSC_SLAVE_ADDR) begin
                d.st = CSC_IDLE;
                d.sda_oe = 1'b0;
              end
            end else begin
              // Command and count bytes are taken and dropped.
              if (q.idx >= CSC_FIRST_DATA_IDX && widx != CSC_STRAP_REG) begin
                d.regs[widx] = q.sh;
              end
              if (q.idx != 3'h7) begin
                d.idx = q.idx + 3'h1;
              end
            end
          end
        end
        CSC_ACK, CSC_RACK: begin
          if (q.st == CSC_RACK && scl && !scl_p) begin
            if (sda) begin
              d.st = CSC_IDLE;
            end else if (q.idx != 3'h7) begin
              d.idx = q.idx + 3'h1;
            end
          end
          if (!scl && scl_p) begin
            if (q.rd) begin
              d.sh = rb;
              d.sda_oe = ~rb[7];
              d.bits = 4'h0;
              d.st = CSC_RD;
            end else begin
              d.sda_oe = 1'b0;
              d.st = CSC_WR;
            end
          end
        end
        CSC_RD: begin
          if (!scl && scl_p) begin
            if (q.bits == 4'h7) begin
              d.sda_oe = 1'b0;
              d.st = CSC_RACK;
            end else begin
              d.bits = q.bits + 4'h1;
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        default: begin
          d.st = CSC_IDLE;
        end
      endcase
    end

    // Software code, when selected, indexes the same table as the straps.
    if (q.regs[0][CSC_R0_SOFT_SEL]) begin
      d.code = {q.regs[0][CSC_R0_SOFT_BIT3], q.regs[0][CSC_R0_SOFT_BIT2],
                q.regs[0][CSC_R0_SOFT_BIT1], q.regs[0][CSC_R0_SOFT_BIT0]};
    end else begin
      d.code = q.fs;
    end
    d.cpu_f = CSC_CPU_TENTHS[q.code];
    d.div = CSC_BUS_DIV[q.code];
    d.ss_en = q.regs[0][CSC_R0_SPREAD_EN];
    d.ss_wide = q.regs[0][CSC_R0_SPREAD_WIDE];
    d.out_oe = ~q.regs[0][CSC_R0_TRISTATE];
    d.ref_oe = q.mode & ~q.regs[0][CSC_R0_TRISTATE] & q.strap_done;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= CSC_IDLE;
      q.regs <= {CSC_NUM_REGS{CSC_ENABLE_RESET}};
      q.regs[0] <= CSC_REG0_RESET;
      q.out_oe <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Output gating
  // ****************************************************************
  assign bus_rise = q.s2[SY_BUS] & ~q.s3[SY_BUS];
  // Halt pins count only in mode 0; in mode 1 they are ignored.
  assign cpu_ok = q.mode | q.s2[SY_CPUH];
  assign pci_ok = q.mode | q.s2[SY_PCIH];

  always_comb begin
    g_src = '0;
    g_en = '0;
    for (int i = 0; i < 2; i++) begin
      g_src[i] = q.s2[SY_HOST];
      g_en[i] = q.regs[1][CSC_R1_HOST1 + i] & cpu_ok;
    end
    g_src[2] = q.s2[SY_REF];
    g_en[2] = q.regs[5][CSC_R5_IRQ0] & cpu_ok;
    for (int i = 0; i < 16; i++) begin
      g_src[3 + i] = q.s2[SY_SDR];
      g_en[3 + i] = q.regs[3][i / 4] & cpu_ok;
    end
    for (int i = 0; i < 5; i++) begin
      g_src[19 + i] = q.s2[SY_BUS];
      g_en[19 + i] = q.regs[2][i] & pci_ok;
    end
    g_src[24] = q.s2[SY_REF];
    g_en[24] = q.regs[5][CSC_R5_REFOUT0];
  end

  for (genvar gi = 0; gi < CSC_NUM_GATES; gi++) begin : g_gate
    csc_clk_gate u_gate (
      .clk(clk),
      .rst(rst),
      .src(g_src[gi]),
      .bus_rise(bus_rise),
      .enable(g_en[gi]),
      .gated(g_out[gi])
    );
  end

  assign host_clk_outputs = g_out[1:0];
  assign irq_ctrl_clk_0 = g_out[2];
  assign sdram_clk_outputs = g_out[18:3];
  assign bus_clk_outputs = g_out[23:19];
  assign reference_out_0 = g_out[24];
  assign reference_out_0_oe = q.ref_oe;
  assign free_running_bus_clk = q.bus_clk;
  assign clk_outputs_oe = q.out_oe;
  assign serial_data_line_o = 1'b0;
  assign serial_data_line_oe = q.sda_oe;
  assign freq_code = q.code;
  assign cpu_freq_tenths_mhz = q.cpu_f;
  assign bus_clk_divisor = q.div;
  assign spread_enable = q.ss_en;
  assign spread_wide = q.ss_wide;
  assign strap_mode = q.mode;
  assign straps_valid = q.strap_done;

endmodule : csc_top

/* File: csc_asserts.sv */
// Port-level assertions for the clock synthesizer control block.
`timescale 1ns/1ps
module csc_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe,
  input wire logic cpu_halt_n,
  input wire logic bus_src_clk,
  input wire logic [1:0] host_clk_outputs,
  input wire logic irq_ctrl_clk_0,
  input wire logic [15:0] sdram_clk_outputs,
  input wire logic [4:0] bus_clk_outputs,
  input wire logic reference_out_0_oe,
  input wire logic clk_outputs_oe,
  input wire logic [3:0] freq_code,
  input wire logic [10:0] cpu_freq_tenths_mhz,
  input wire logic [2:0] bus_clk_divisor,
  input wire logic strap_mode,
  input wire logic straps_valid
);
  // ****************************************************************
  // Halt timer
  // ****************************************************************
  // A stop waits for a bus clock rise and an output fall, so 31 cycles is ample.
  logic [4:0] halt_q;
  always_ff @(posedge clk) begin
    if (rst || strap_mode || !straps_valid || cpu_halt_n) begin
      halt_q <= 5'h00;
    end else if (halt_q != 5'h1F) begin
      halt_q <= halt_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_open_drain;
    serial_data_line_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin drives high");
  property p_sda_moves;
    $changed(serial_data_line_oe) |-> !serial_clock_line;
  endproperty
  a_sda_moves: assert property (p_sda_moves) else $error("data moved at clock high");
  property p_strap_catch;
    $fell(rst) |-> ##[1:6] straps_valid;
  endproperty
  a_strap_catch: assert property (p_strap_catch) else $error("straps not caught");
  property p_strap_hold;
    straps_valid && $past(straps_valid) |-> $stable(strap_mode);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("mode strap changed");
  property p_decode;
    straps_valid && $stable(freq_code) && freq_code == $past(freq_code, 3) |->
      (freq_code != 4'hD || {cpu_freq_tenths_mhz, bus_clk_divisor} == {11'h5DC, 3'h4}) &&
      (freq_code != 4'h5 || {cpu_freq_tenths_mhz, bus_clk_divisor} == {11'h460, 3'h3});
  endproperty
  a_decode: assert property (p_decode) else $error("frequency decode wrong");
  property p_ref_oe;
    reference_out_0_oe |-> strap_mode && straps_valid && (clk_outputs_oe || $past(clk_outputs_oe));
  endproperty
  a_ref_oe: assert property (p_ref_oe) else $error("pin 3 driven wrongly");
  property p_cpu_halt;
    halt_q == 5'h1F |-> {host_clk_outputs, irq_ctrl_clk_0, sdram_clk_outputs} == 19'h0;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt) else $error("halted clock still runs");
  property p_gate_fall;
    $fell(bus_clk_outputs[0]) |->
      !$past(bus_src_clk, 2) || !$past(bus_src_clk, 3) || !$past(bus_src_clk, 4);
  endproperty
  a_gate_fall: assert property (p_gate_fall) else $error("high pulse cut short");
  c_ack: cover property ($rose(serial_data_line_oe));
  c_catch: cover property ($rose(straps_valid));
  c_halt: cover property (halt_q == 5'h1F);
endmodule : csc_asserts

bind csc_top csc_asserts i_csc_asserts (
  .clk, .rst, .serial_clock_line, .serial_data_line_o, .serial_data_line_oe, .cpu_halt_n,
  .bus_src_clk, .host_clk_outputs, .irq_ctrl_clk_0, .sdram_clk_outputs, .bus_clk_outputs,
  .reference_out_0_oe, .clk_outputs_oe, .freq_code, .cpu_freq_tenths_mhz, .bus_clk_divisor,
  .strap_mode, .straps_valid
);

/* File: csc_master.sv */
// Two-wire bus master model that talks to the control block's serial slave.
`timescale 1ns/1ps
module csc_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // A bit lasts eight block clocks; the clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, r);
    ack = ~r;
  endtask : byte_io
  task automatic frame(input logic [7:0] addr, input int n, input logic [7:0][7:0] wd,
                       output logic [7:0][7:0] rd, output logic [10:0] acks);
    logic [7:0] q;
    logic last;
    rd = '0;
    acks = '0;
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
    byte_io(addr, 1'b1, q, acks[0]);
    if (!addr[0]) begin
      byte_io(8'h00, 1'b1, q, acks[1]);
      byte_io(8'(n), 1'b1, q, acks[2]);
    end
    for (int i = 0; i < n; i++) begin
      last = addr[0] ? (i == n - 1) : 1'b1;
      byte_io(addr[0] ? 8'hFF : wd[i], last, rd[i], acks[i + 3]);
    end
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask : frame
endmodule : csc_master

/* File: tb_clock_synth_control.sv */
// Self-checking bench for the clock synthesizer control block.
`timescale 1ns/1ps
module tb_clock_synth_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpu_halt_n = 1'b1;
  logic reference_out_0_i = 1'b1;
  logic mode_strap_pin = 1'b0;
  logic [3:0] freq_strap_pins = 4'hD;
  logic [2:0] ph = 3'h0;
  logic host_src_clk, sdram_src_clk, bus_src_clk, ref_src_clk, serial_clock_line, sda_drv;
  logic serial_data_line_i, serial_data_line_o, serial_data_line_oe, irq_ctrl_clk_0;
  logic reference_out_0, reference_out_0_oe, free_running_bus_clk, clk_outputs_oe;
  logic spread_enable, spread_wide, strap_mode, straps_valid;
  logic [1:0] host_clk_outputs;
  logic [15:0] sdram_clk_outputs;
  logic [4:0] bus_clk_outputs;
  logic [3:0] freq_code;
  logic [10:0] cpu_freq_tenths_mhz;
  logic [2:0] bus_clk_divisor;
  logic [7:0][7:0] rdata;
  logic [10:0] acks;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // Oscillator settling time before outputs are re-enabled: 3 ms of 50 ns cycles.
  localparam int SETTLE_CYCLES = 60000;
  always #25 clk = ~clk;
  always @(negedge clk) ph <= ph + 3'h1;
  assign bus_src_clk = ph[2];
  assign sdram_src_clk = ~ph[2];
  assign host_src_clk = ph[2] ^ ph[1];
  assign ref_src_clk = ~(ph[2] ^ ph[1]);
  // The data wire has a pull-up, so it reads high unless someone pulls it low.
  assign serial_data_line_i = sda_drv & (serial_data_line_oe !== 1'b1);
  csc_top i_dut (
    .clk, .rst, .serial_clock_line, .serial_data_line_i, .serial_data_line_o,
    .serial_data_line_oe, .cpu_halt_n, .reference_out_0_i, .host_src_clk, .sdram_src_clk,
    .bus_src_clk, .ref_src_clk, .freq_strap_pins, .mode_strap_pin, .host_clk_outputs,
    .irq_ctrl_clk_0, .sdram_clk_outputs, .bus_clk_outputs, .reference_out_0,
    .reference_out_0_oe, .free_running_bus_clk, .clk_outputs_oe, .freq_code,
    .cpu_freq_tenths_mhz, .bus_clk_divisor, .spread_enable, .spread_wide, .strap_mode,
    .straps_valid
  );
  csc_master i_mst (.clk, .sda(serial_data_line_i), .scl(serial_clock_line), .sda_drv);
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strap readback bytes 5 and 4 as the latch stores them.
  function automatic logic [15:0] sb(input logic [3:0] s);
    return {1'b1, s[2], 6'h3F, s[0], 3'h7, s[1], 1'b1, s[3], 1'b1};
  endfunction : sb
  task automatic do_reset(input logic [3:0] fs, input logic mode);
    @(negedge clk);
    rst = 1'b1;
    freq_strap_pins = fs;
    mode_strap_pin = mode;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask : do_reset
  task automatic rd_all(input logic [47:0] exp);
    i_mst.frame(8'hD3, 6, 64'h0, rdata, acks);
    chk({acks[0], rdata[5:0]}, {1'b1, exp});
  endtask : rd_all
  task automatic wr(input int n, input logic [63:0] d);
    i_mst.frame(8'hD2, n, d, rdata, acks);
    repeat (8) @(negedge clk);
  endtask : wr
  task automatic t_run(input logic [23:0] want);
    logic [23:0] seen;
    logic [1:0] free_seen;
    seen = '0;
    free_seen = '0;
    repeat (24) @(negedge clk);
    repeat (48) @(negedge clk) begin
      seen |= {host_clk_outputs, irq_ctrl_clk_0, sdram_clk_outputs, bus_clk_outputs};
      free_seen |= {free_running_bus_clk, reference_out_0};
    end
    chk(seen, want);
    chk(free_seen, 2'h3);
  endtask : t_run
  task automatic t_defaults;
    chk({straps_valid, strap_mode, freq_code}, 6'h2D);
    chk({cpu_freq_tenths_mhz, bus_clk_divisor}, {11'h5DC, 3'h4});
    chk({spread_enable, spread_wide, clk_outputs_oe, reference_out_0_oe}, 4'h2);
    rd_all({sb(4'hD), 24'hFFFFFF, 8'h00});
  endtask : t_defaults
  task automatic t_write;
    repeat (SETTLE_CYCLES) @(negedge clk);
    wr(6, 64'hFF00FFFFFDDA);
    chk(acks[5:0], 6'h3F);
    chk({freq_code, cpu_freq_tenths_mhz, bus_clk_divisor}, {4'h5, 11'h460, 3'h3});
    chk({spread_enable, spread_wide}, 2'h3);
    rd_all({sb(4'hD), 16'hFFFF, 8'hFD, 8'hDA});
    i_mst.frame(8'hA4, 1, 64'h01, rdata, acks);
    chk({acks[0], clk_outputs_oe}, 2'h1);
  endtask : t_write
  task automatic t_tristate;
    wr(1, 64'h01);
    chk({clk_outputs_oe, spread_enable, freq_code, cpu_freq_tenths_mhz}, {6'h0D, 11'h5DC});
    wr(1, 64'h00);
    chk(clk_outputs_oe, 1'b1);
  endtask : t_tristate
  task automatic t_gate;
    t_run({2'h2, 1'b1, 16'hFFFF, 5'h1F});
    cpu_halt_n = 1'b0;
    t_run({2'h0, 1'b0, 16'h0000, 5'h1F});
    cpu_halt_n = 1'b1;
    reference_out_0_i = 1'b0;
    t_run({2'h2, 1'b1, 16'hFFFF, 5'h00});
    reference_out_0_i = 1'b1;
  endtask : t_gate
  task automatic t_mode1;
    do_reset(4'h0, 1'b1);
    freq_strap_pins = 4'hF;
    cpu_halt_n = 1'b0;
    reference_out_0_i = 1'b0;
    t_run(24'hFFFFFF);
    chk({strap_mode, reference_out_0_oe, freq_code}, 6'h30);
    chk({cpu_freq_tenths_mhz, bus_clk_divisor}, {11'h4D8, 3'h3});
  endtask : t_mode1
  initial begin
    do_reset(4'hD, 1'b0);
    t_defaults();
    t_write();
    t_tristate();
    t_gate();
    t_mode1();
    stop_test();
  end
endmodule : tb_clock_synth_control
